//--- pkg/spc_pkg.sv
// constants and types shared by the sleep button power control block
package spc_pkg;
    // blink half period of the low-power glyph while asleep (time and derived cycles)
    localparam int unsigned GLYPH_HALF_PERIOD_MS = 500;
    localparam int unsigned CLK_PERIOD_NS        = 8;
    localparam int unsigned GLYPH_HALF_CYCLES    = (GLYPH_HALF_PERIOD_MS * 1000000) / CLK_PERIOD_NS;
    localparam int unsigned GLYPH_CNT_W          = 26;
    // reset values
    localparam logic        RST_GLYPH            = 1'b0;
    localparam logic [2:0]  RST_SYNC             = 3'h0;
    // power mode of the device
    typedef enum logic [1:0]
    {
        SPC_AWAKE   = 2'b00,
        SPC_PRESSED = 2'b01,
        SPC_ASLEEP  = 2'b10
    } spc_mode_t;
endpackage

//--- hdl/spc_pin_sync.sv
// three-stage synchroniser with second/third agreement and edge pulses
`timescale 1ns/1ns
`default_nettype none
module spc_pin_sync
(
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic pin,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    import spc_pkg::*;

    typedef struct packed
    {
        logic [2:0] sync;
        logic       level;
        logic       rise;
        logic       fall;
    } spc_sync_st_t;

    spc_sync_st_t st;
    spc_sync_st_t next_st;

    ////////////////////////////////////////////////////////////////////////
    // stage 0 is read only by stage 1; level moves when stages 1 and 2 agree
    always_comb
    begin
        next_st      = st;
        next_st.sync = {st.sync[1:0], pin};
        next_st.rise = 1'b0;
        next_st.fall = 1'b0;
        if (st.sync[1] == st.sync[2] && st.sync[2] != st.level)
        begin
            next_st.level = st.sync[2];
            next_st.rise  = st.sync[2];
            next_st.fall  = ~st.sync[2];
        end
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            st <= '{sync: RST_SYNC, level: 1'b0, rise: 1'b0, fall: 1'b0};
        else
            st <= next_st;
    end

    assign level = st.level;
    assign rise  = st.rise;
    assign fall  = st.fall;
endmodule
`default_nettype wire

//--- hdl/spc_top.sv
// sleep button power control: edge events, sleep/wake sequencing, glyph blink
`timescale 1ns/1ns
`default_nettype none
module spc_top
(
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic sleep_button,
    input  wire logic mains_presence_input,
    input  wire logic battery_sense,
    input  wire logic clock_menu_active,
    output logic      sleep_push_handler,
    output logic      sleep_request,
    output logic      wake_pulse,
    output logic      low_power,
    output logic      rtc_enable,
    output logic      function_enable,
    output logic      low_power_glyph,
    output logic      on_mains
);
    import spc_pkg::*;

    typedef struct packed
    {
        spc_mode_t              mode;
        logic                   sleep_req;
        logic                   wake;
        logic                   glyph;
        logic [GLYPH_CNT_W-1:0] blink_cnt;
        logic [2:0]             mains_sync;
        logic                   mains_level;
        logic                   mains;
        logic                   event_out;
    } spc_st_t;

    spc_st_t st;
    spc_st_t next_st;
    logic    btn_level;
    logic    btn_rise;
    logic    btn_fall;

    ////////////////////////////////////////////////////////////////////////
    // button conditioning
    spc_pin_sync u_btn
    (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .pin     (sleep_button),
        .level   (btn_level),
        .rise    (btn_rise),
        .fall    (btn_fall)
    );

    ////////////////////////////////////////////////////////////////////////
    // mains is wall power only if present and battery sense is low; battery sense overrides presence
    function automatic logic sleep_blocked(input logic mains, input logic menu);
        sleep_blocked = mains & menu;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // mode sequencing, blink counter and event output
    always_comb
    begin
        next_st            = st;
        next_st.mains_sync = {st.mains_sync[1:0], mains_presence_input};
        // battery gating applies every cycle so a battery change never waits on the pin
        if (st.mains_sync[1] == st.mains_sync[2])
            next_st.mains_level = st.mains_sync[2];
        next_st.mains = next_st.mains_level & ~battery_sense;
        next_st.event_out = btn_rise | btn_fall;
        next_st.sleep_req = 1'b0;
        next_st.wake      = 1'b0;
        case (st.mode)
            SPC_AWAKE:
            begin
                if (btn_rise)
                    next_st.mode = SPC_PRESSED;
            end
            SPC_PRESSED:
            begin
                // a block at release drops the request; a later press retries
                if (btn_fall)
                begin
                    if (sleep_blocked(st.mains, clock_menu_active))
                        next_st.mode = SPC_AWAKE;
                    else
                    begin
                        next_st.mode      = SPC_ASLEEP;
                        next_st.sleep_req = 1'b1;
                        next_st.blink_cnt = '0;
                        next_st.glyph     = 1'b1;
                    end
                end
            end
            SPC_ASLEEP:
            begin
                if (btn_rise)
                begin
                    // the wake press also starts a new press cycle in SPC_PRESSED, so its release can sleep again
                    next_st.mode  = SPC_PRESSED;
                    next_st.wake  = 1'b1;
                    next_st.glyph = RST_GLYPH;
                end
                else if (st.blink_cnt == GLYPH_CNT_W'(GLYPH_HALF_CYCLES - 1))
                begin
                    next_st.blink_cnt = '0;
                    next_st.glyph     = ~st.glyph;
                end
                else
                    next_st.blink_cnt = st.blink_cnt + GLYPH_CNT_W'(1);
            end
            default:
            begin
                next_st.mode = SPC_AWAKE;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            st <= '{mode: SPC_AWAKE, sleep_req: 1'b0, wake: 1'b0, glyph: RST_GLYPH,
                    blink_cnt: '0, mains_sync: RST_SYNC, mains_level: 1'b0, mains: 1'b0,
                    event_out: 1'b0};
        else
            st <= next_st;
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs from flip-flops, except low_power and function_enable decoded from mode, and rtc_enable which is tied high
    assign sleep_push_handler = st.event_out;
    assign sleep_request      = st.sleep_req;
    assign wake_pulse         = st.wake;
    assign low_power          = (st.mode == SPC_ASLEEP);
    assign rtc_enable         = 1'b1;
    assign function_enable    = (st.mode != SPC_ASLEEP);
    assign low_power_glyph    = st.glyph;
    assign on_mains           = st.mains;
endmodule
`default_nettype wire

//--- tb/spc_button.sv
// push-button model driving the sleep button pin
`timescale 1ns/1ns
`default_nettype none
module spc_button
(
    input  wire logic finger,
    output logic      pin
);
    // contact closes shortly after the finger moves
    assign #2 pin = finger;
endmodule
`default_nettype wire

//--- tb/spc_top_sva.sv
// assertions on the sleep button power control ports
`timescale 1ns/1ns
`default_nettype none
module spc_top_sva
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic sleep_button,
    input wire logic mains_presence_input,
    input wire logic battery_sense,
    input wire logic clock_menu_active,
    input wire logic sleep_push_handler,
    input wire logic sleep_request,
    input wire logic wake_pulse,
    input wire logic low_power,
    input wire logic rtc_enable,
    input wire logic function_enable,
    input wire logic low_power_glyph,
    input wire logic on_mains
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_evt; sleep_push_handler |=> !sleep_push_handler; endproperty
    a_evt: assert property (p_evt) else $error("event too long");
    property p_req; sleep_request |-> $rose(low_power); endproperty
    a_req: assert property (p_req) else $error("request without sleep");
    property p_ent; $rose(low_power) |-> sleep_request && low_power_glyph; endproperty
    a_ent: assert property (p_ent) else $error("bad sleep entry");
    property p_wk; $fell(low_power) |-> wake_pulse && sleep_push_handler; endproperty
    a_wk: assert property (p_wk) else $error("bad wake");
    property p_rtc; rtc_enable; endproperty
    a_rtc: assert property (p_rtc) else $error("clock off");
    property p_fen; function_enable == !low_power; endproperty
    a_fen: assert property (p_fen) else $error("functions wrong");
    property p_blk; sleep_request |-> !($past(on_mains) && $past(clock_menu_active)); endproperty
    a_blk: assert property (p_blk) else $error("sleep not held off");
    property p_bat; $past(battery_sense) |-> !on_mains; endproperty
    a_bat: assert property (p_bat) else $error("battery ignored");
endmodule
bind spc_top spc_top_sva u_sva (.*);
`default_nettype wire

//--- tb/testbench.sv
// bench for the sleep button power control
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic ref_clk = 1'b0, nrst = 1'b0, finger = 1'b0, mains = 1'b0, bat = 1'b1, menu = 1'b1;
    logic pin, evt, lp, fen, gly, onm, req, wk, rtc;
    int   fails = 0, checks_done = 0, cyc = 0;
    always #4 ref_clk = ~ref_clk;
    spc_button partner (.finger(finger), .pin(pin));
    spc_top dut (.ref_clk(ref_clk), .nrst(nrst), .sleep_button(pin), .mains_presence_input(mains),
        .battery_sense(bat), .clock_menu_active(menu), .sleep_push_handler(evt), .sleep_request(req),
        .wake_pulse(wk), .low_power(lp), .rtc_enable(rtc), .function_enable(fen), .low_power_glyph(gly),
        .on_mains(onm));
    task automatic chk(logic got, logic exp);
        checks_done++;
        if (got !== exp)
        begin
            fails++;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic close_out;
        $display("fails %0d checks %0d", fails, checks_done);
        if (fails == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // one button edge, then the settled power state
    task automatic edge_to(logic v, logic exp_lp, logic exp_req, logic exp_wk);
        int n;
        finger = v;
        for (n = 0; evt !== 1'b1 && n < 20; n++)
            @(posedge ref_clk) #1;
        chk(evt, 1'b1);
        chk(req, exp_req);
        chk(wk, exp_wk);
        chk(rtc, 1'b1);
        @(posedge ref_clk) #1;
        chk(lp, exp_lp);
        chk(fen, !exp_lp);
        chk(gly, exp_lp);
        repeat (3) @(posedge ref_clk) #1;
    endtask
    // battery: clock menu ignored, press wakes
    task automatic t_battery;
        edge_to(1'b1, 1'b0, 1'b0, 1'b0);
        edge_to(1'b0, 1'b1, 1'b1, 1'b0);
        edge_to(1'b1, 1'b0, 1'b0, 1'b1);
    endtask
    // mains: clock menu holds off sleep, sleep proceeds with it inactive
    task automatic t_mains;
        bat = 1'b0;
        mains = 1'b1;
        repeat (8) @(posedge ref_clk) #1;
        chk(onm, 1'b1);
        edge_to(1'b0, 1'b0, 1'b0, 1'b0);
        menu = 1'b0;
        edge_to(1'b1, 1'b0, 1'b0, 1'b0);
        edge_to(1'b0, 1'b1, 1'b1, 1'b0);
        menu = 1'b1;
        edge_to(1'b1, 1'b0, 1'b0, 1'b1);
        edge_to(1'b0, 1'b0, 1'b0, 1'b0);
    endtask
    initial
    begin
        repeat (3) @(posedge ref_clk) #1;
        nrst = 1'b1;
        repeat (2) @(posedge ref_clk) #1;
        t_battery();
        t_mains();
        close_out();
    end
    // hang guard
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            fails++;
            close_out();
        end
    end
endmodule
`default_nettype wire
